// ==== src/pms_pkg.sv ====
// pms_pkg: constants shared by the power sequencer, its register map and field layout.
// assumes an APB slave with 32-bit data and one aligned word per register.
package pms_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // sizes and clock rates
  localparam int          NUM_RES       = 8;        // managed resources (at most 8)
  localparam int          NUM_CLK       = 4;        // core clock request lines
  localparam int          TIMER_W       = 8;        // transition timer width, low-power ticks
  localparam int          ADDR_W        = 12;       // apb byte address width
  localparam int          PCLK_HZ       = 125000000; // bus clock rate
  localparam int          LPO_HZ        = 32768;    // low-power clock rate
  localparam logic [15:0] CAL_NOMINAL   = 16'(PCLK_HZ / LPO_HZ); // bus cycles per tick

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [11:0] OFS_MIN_SET   = 12'h000;  // minimum_resource_set
  localparam logic [11:0] OFS_CTRL      = 12'h004;  // mode request, pull-down control
  localparam logic [11:0] OFS_REQ_TIMER = 12'h008;  // resource-request timer
  localparam logic [11:0] OFS_STATUS    = 12'h00C;  // flags and mode, read only
  localparam logic [11:0] OFS_CAL       = 12'h010;  // measured bus cycles per tick
  localparam logic [11:0] OFS_CLK_MAP   = 12'h020;  // one word per clock request line
  localparam logic [11:0] OFS_RES_CFG   = 12'h040;  // one word per resource

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int CTRL_MODE_LSB  = 0;   // control: mode request, 2 bits
  localparam int CTRL_PD_DIS    = 2;   // control: 1 disables the enable-pin pull-down
  localparam int RT_CNT_LSB     = 0;   // request timer: tick count, 16 bits
  localparam int RT_MASK_LSB    = 16;  // request timer: resource mask
  localparam int CFG_TON_LSB    = 0;   // resource cfg: turn-on delay
  localparam int CFG_TOFF_LSB   = 8;   // resource cfg: turn-off delay
  localparam int CFG_DEP_LSB    = 16;  // resource cfg: dependency mask
  localparam int ST_ON_LSB      = 0;   // status: resource_on_flag
  localparam int ST_TRANS_LSB   = 8;   // status: resource_transition_flag
  localparam int ST_MODE_LSB    = 16;  // status: current mode, 3 bits

  ////////////////////////////////////////////////////////////////////////////
  // mode requests and power modes
  localparam logic [1:0] REQ_ACTIVE = 2'h0;  // stay active
  localparam logic [1:0] REQ_DOZE   = 2'h1;  // enter doze
  localparam logic [1:0] REQ_DEEP   = 2'h2;  // enter deep-sleep

  typedef enum logic [2:0] {
    PMS_OFF,      // regulators off, held in reset
    PMS_ACTIVE,   // clocks running
    PMS_DOZE,     // main clocks stopped
    PMS_SAVE,     // saving core state to retention
    PMS_DEEP,     // core power off
    PMS_RESTORE   // restoring core state
  } pms_mode_t;

endpackage : pms_pkg

// ==== src/pms_resource_sequencer.sv ====
// pms_resource_sequencer: resource request resolution, per-resource on/off sequencing,
// power modes and the regulator-enable pins, with an apb register file.
// assumes all inputs, low_power_clock included, are synchronous to pclk.
//
// Notes on behaviour
// - requests: clocks, minimum set, request timers
// - clock requests mapped to resource sets
// - each resource in one of four states
// - timer zero when settled, nonzero in transition
// - load delay, count down per tick
// - timer zero ends the transition
// - zero delay switches immediately
// - required set recomputed every tick
// - expiry clears pending, inverts on flag
// - disable unrequested resources without powered dependents
// - enable requested resources with dependencies on
// - doze stops main clocks, sequencer wakes
// - deep-sleep saves, wakes, restores core state
// - power-down leaves only on regulator re-enable
// - shutdown tristates outputs, disables inputs
// - power-up after shutdown retains nothing
// - enable pin high runs, low resets
// - enable pin pull-down, software can disable
// - hibernate input low disables regulators
// - tick period calibrated against bus clock
// - active enables regulators, slows clocks; fast_clk_sel is set only in active or restore, while a core clock request is high
// - programmable sequences via low-power counters
`timescale 1ns/100ps

module pms_resource_sequencer #(
  parameter int NUM_RES = pms_pkg::NUM_RES,  // managed resources, at most 8
  parameter int NUM_CLK = pms_pkg::NUM_CLK,  // clock request lines
  parameter int TIMER_W = pms_pkg::TIMER_W   // transition timer width
) (
  input  wire  logic                         pclk,
  input  wire  logic                         presetn,
  input  wire  logic                         psel,
  input  wire  logic                         penable,
  input  wire  logic                         pwrite,
  input  wire  logic [pms_pkg::ADDR_W-1:0]   paddr,
  input  wire  logic [31:0]                  pwdata,
  output logic       [31:0]                  prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire  logic                         low_power_clock,
  input  wire  logic [NUM_CLK-1:0]           core_clk_req,
  input  wire  logic                         wake_irq,
  input  wire  logic                         regulator_enable_in,
  input  wire  logic                         hibernate_regulator_enable_in,
  output logic                               hibernate_regulator_enable_out,
  output logic                               regulator_pulldown_en,
  output logic                               regulators_on,
  output logic [NUM_RES-1:0]                 resource_enable,
  output logic                               main_clk_en,
  output logic                               fast_clk_sel,
  output logic                               core_power_en,
  output logic                               core_reset_n,
  output logic                               retention_save,
  output logic                               retention_restore,
  output logic                               io_output_enable_n,
  output logic                               io_input_en
);

  ////////////////////////////////////////////////////////////////////////////
  // whole state of the block
  typedef struct packed {
    logic [NUM_RES-1:0]                on;        // resource_on_flag
    logic [NUM_RES-1:0]                trans;     // resource_transition_flag
    logic [NUM_RES-1:0][TIMER_W-1:0]   tmr;       // transition timers
    logic [NUM_RES-1:0][TIMER_W-1:0]   ton;       // turn-on delays
    logic [NUM_RES-1:0][TIMER_W-1:0]   toff;      // turn-off delays
    logic [NUM_RES-1:0][NUM_RES-1:0]   dep;       // dep[i][j]: i needs j
    logic [NUM_CLK-1:0][NUM_RES-1:0]   clk_map;   // resources per clock request
    logic [NUM_RES-1:0]                min_set;   // minimum_resource_set
    logic [1:0]                        mode_req;  // software mode request
    logic                              pd_dis;    // pull-down disabled
    logic [15:0]                       rt_cnt;    // request timer ticks left
    logic [NUM_RES-1:0]                rt_mask;   // request timer resources
    pms_pkg::pms_mode_t                mode;      // power mode
    logic                              lpo_q;     // low-power clock last sample
    logic [15:0]                       cal_cnt;   // bus cycles in current tick
    logic [15:0]                       cal_per;   // measured tick period
    logic [31:0]                       prdata;    // apb read data
    logic                              pready;    // apb ready
    logic                              pslverr;   // apb error
    logic                              hib_out;   // hibernate enable out
    logic                              pd_en;     // pull-down enable
    logic                              reg_on;    // regulators enabled
    logic [NUM_RES-1:0]                res_en;    // resource switch enables
    logic                              main_clk;  // main clocks enable
    logic                              fast_clk;  // fast clock select
    logic                              core_pwr;  // core power enable
    logic                              core_rst_n; // core reset, active low
    logic                              save;      // retention save pulse
    logic                              restore;   // retention restore pulse
    logic                              io_oe_n;   // outputs tristated
    logic                              io_in_en;  // inputs enabled
  } pms_state_t;

  pms_state_t s;       // registered state
  pms_state_t next_s;  // next state

  ////////////////////////////////////////////////////////////////////////////
  // combinational helpers
  logic                 tick;        // low-power clock rising edge
  logic [NUM_RES-1:0]   req;         // gathered requests
  logic [NUM_RES-1:0]   required;    // requests closed over dependencies
  logic [NUM_RES-1:0]   dep_up;      // resource has a powered dependent
  logic [NUM_RES-1:0]   dep_ready;   // all dependencies fully enabled
  logic                 rt_expire;   // request timer reaches zero
  logic                 wake;        // wake event
  logic                 wr;          // apb write takes effect
  logic [9:0]           widx;        // word index of paddr
  logic [9:0]           cmi;         // clock map word offset
  logic [9:0]           rci;         // resource cfg word offset

  // close a request set over the dependency table
  function automatic logic [NUM_RES-1:0] close_set(
    input logic [NUM_RES-1:0]              r_in,
    input logic [NUM_RES-1:0][NUM_RES-1:0] d_in
  );
    logic [NUM_RES-1:0] r;
    r = r_in;
    for (int p = 0; p < NUM_RES; p++) begin
      for (int i = 0; i < NUM_RES; i++) begin
        if (r[i]) begin
          r = r | d_in[i];
        end
      end
    end
    return r;
  endfunction : close_set

  ////////////////////////////////////////////////////////////////////////////
  // request gathering and resource readiness
  always_comb begin
    tick      = low_power_clock & ~s.lpo_q;
    rt_expire = tick & (s.rt_cnt == 16'h0001);
    req       = s.min_set;
    if (s.rt_cnt != 16'h0000) begin
      req = req | s.rt_mask;
    end
    for (int c = 0; c < NUM_CLK; c++) begin
      if (core_clk_req[c]) begin
        req = req | s.clk_map[c];
      end
    end
    required = close_set(req, s.dep);
    for (int i = 0; i < NUM_RES; i++) begin
      dep_up[i]    = 1'b0;
      dep_ready[i] = ((s.dep[i] & ~(s.on & ~s.trans)) == '0);
      for (int j = 0; j < NUM_RES; j++) begin
        if (s.dep[j][i] && (s.on[j] || s.trans[j])) begin
          dep_up[i] = 1'b1;
        end
      end
    end
    wake = rt_expire | wake_irq;
    wr   = psel & penable & s.pready & pwrite;
    widx = paddr[11:2];
    cmi  = widx - pms_pkg::OFS_CLK_MAP[11:2];
    rci  = widx - pms_pkg::OFS_RES_CFG[11:2];
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_s = s;
    next_s.lpo_q   = low_power_clock;
    next_s.hib_out = hibernate_regulator_enable_in;
    // apb: setup cycle decodes, access cycle answers
    next_s.pready  = psel & ~penable;
    next_s.pslverr = 1'b0;
    next_s.save    = 1'b0;
    next_s.restore = 1'b0;

    // tick period measurement against the crystal-derived bus clock
    if (tick) begin
      next_s.cal_per = s.cal_cnt + 16'h0001;
      next_s.cal_cnt = 16'h0000;
    end else if (s.cal_cnt != 16'hFFFF) begin
      next_s.cal_cnt = s.cal_cnt + 16'h0001;
    end

    // request timer counts low-power ticks
    if (tick && s.rt_cnt != 16'h0000) begin
      next_s.rt_cnt = s.rt_cnt - 16'h0001;
    end

    // resource sequencing, once per low-power tick
    if (tick) begin
      for (int i = 0; i < NUM_RES; i++) begin
        if (s.trans[i]) begin
          // in transition: count down, settle on reaching zero
          if (s.tmr[i] <= TIMER_W'(1)) begin
            next_s.tmr[i]   = '0;
            next_s.trans[i] = 1'b0;
            next_s.on[i]    = ~s.on[i];
          end else begin
            next_s.tmr[i] = s.tmr[i] - TIMER_W'(1);
          end
        end else if (s.on[i] && !required[i] && !dep_up[i]) begin
          // disable sequence
          if (s.toff[i] == '0) begin
            next_s.on[i] = 1'b0;
          end else begin
            next_s.trans[i] = 1'b1;
            next_s.tmr[i]   = s.toff[i];
          end
        end else if (!s.on[i] && required[i] && dep_ready[i]) begin
          // enable sequence
          if (s.ton[i] == '0) begin
            next_s.on[i] = 1'b1;
          end else begin
            next_s.trans[i] = 1'b1;
            next_s.tmr[i]   = s.ton[i];
          end
        end
      end
    end

    // power mode machine
    case (s.mode)
      pms_pkg::PMS_OFF: begin
        next_s.mode = pms_pkg::PMS_ACTIVE;
      end
      pms_pkg::PMS_ACTIVE: begin
        if (s.mode_req == pms_pkg::REQ_DOZE) begin
          next_s.mode = pms_pkg::PMS_DOZE;
        end else if (s.mode_req == pms_pkg::REQ_DEEP) begin
          next_s.mode = pms_pkg::PMS_SAVE;
          next_s.save = 1'b1;
        end
      end
      pms_pkg::PMS_DOZE: begin
        if (wake || core_clk_req != '0) begin
          next_s.mode     = pms_pkg::PMS_ACTIVE;
          next_s.mode_req = pms_pkg::REQ_ACTIVE;
        end
      end
      pms_pkg::PMS_SAVE: begin
        next_s.mode = pms_pkg::PMS_DEEP;
      end
      pms_pkg::PMS_DEEP: begin
        if (wake) begin
          next_s.mode    = pms_pkg::PMS_RESTORE;
          next_s.restore = 1'b1;
        end
      end
      pms_pkg::PMS_RESTORE: begin
        next_s.mode     = pms_pkg::PMS_ACTIVE;
        next_s.mode_req = pms_pkg::REQ_ACTIVE;
      end
      default: begin
        next_s.mode = pms_pkg::PMS_OFF;
      end
    endcase

    // apb read data, decoded in the setup cycle
    if (psel && !penable) begin
      next_s.prdata = 32'h0000_0000;
      if (paddr[1:0] != 2'b00) begin
        next_s.pslverr = 1'b1;
      end else if (paddr == pms_pkg::OFS_MIN_SET) begin
        next_s.prdata[NUM_RES-1:0] = s.min_set;
      end else if (paddr == pms_pkg::OFS_CTRL) begin
        next_s.prdata[pms_pkg::CTRL_MODE_LSB +: 2] = s.mode_req;
        next_s.prdata[pms_pkg::CTRL_PD_DIS]        = s.pd_dis;
      end else if (paddr == pms_pkg::OFS_REQ_TIMER) begin
        next_s.prdata[pms_pkg::RT_CNT_LSB +: 16]       = s.rt_cnt;
        next_s.prdata[pms_pkg::RT_MASK_LSB +: NUM_RES] = s.rt_mask;
      end else if (paddr == pms_pkg::OFS_STATUS) begin
        next_s.prdata[pms_pkg::ST_ON_LSB +: NUM_RES]    = s.on;
        next_s.prdata[pms_pkg::ST_TRANS_LSB +: NUM_RES] = s.trans;
        next_s.prdata[pms_pkg::ST_MODE_LSB +: 3]        = s.mode;
      end else if (paddr == pms_pkg::OFS_CAL) begin
        next_s.prdata[15:0] = s.cal_per;
      end else if (cmi < 10'(NUM_CLK)) begin
        next_s.prdata[NUM_RES-1:0] = s.clk_map[cmi[2:0]];
      end else if (rci < 10'(NUM_RES)) begin
        next_s.prdata[pms_pkg::CFG_TON_LSB +: TIMER_W]  = s.ton[rci[2:0]];
        next_s.prdata[pms_pkg::CFG_TOFF_LSB +: TIMER_W] = s.toff[rci[2:0]];
        next_s.prdata[pms_pkg::CFG_DEP_LSB +: NUM_RES]  = s.dep[rci[2:0]];
      end else begin
        next_s.pslverr = 1'b1;                                // unmapped
      end
    end

    // apb write, taken at the access edge; the error flag falls with ready
    if (psel && penable) begin
      next_s.pslverr = 1'b0;
    end
    if (wr && !s.pslverr) begin
      if (paddr == pms_pkg::OFS_MIN_SET) begin
        next_s.min_set = pwdata[NUM_RES-1:0];
      end else if (paddr == pms_pkg::OFS_CTRL) begin
        next_s.mode_req = pwdata[pms_pkg::CTRL_MODE_LSB +: 2];
        next_s.pd_dis   = pwdata[pms_pkg::CTRL_PD_DIS];
      end else if (paddr == pms_pkg::OFS_REQ_TIMER) begin
        next_s.rt_cnt  = pwdata[pms_pkg::RT_CNT_LSB +: 16];
        next_s.rt_mask = pwdata[pms_pkg::RT_MASK_LSB +: NUM_RES];
      end else if (cmi < 10'(NUM_CLK)) begin
        next_s.clk_map[cmi[2:0]] = pwdata[NUM_RES-1:0];
      end else if (rci < 10'(NUM_RES)) begin
        next_s.ton[rci[2:0]]  = pwdata[pms_pkg::CFG_TON_LSB +: TIMER_W];
        next_s.toff[rci[2:0]] = pwdata[pms_pkg::CFG_TOFF_LSB +: TIMER_W];
        next_s.dep[rci[2:0]]  = pwdata[pms_pkg::CFG_DEP_LSB +: NUM_RES];
      end
    end

    // outputs derived from the next state
    next_s.pd_en      = ~next_s.pd_dis;
    next_s.reg_on     = (next_s.mode != pms_pkg::PMS_OFF);
    next_s.res_en     = next_s.on ^ next_s.trans;
    next_s.main_clk   = (next_s.mode == pms_pkg::PMS_ACTIVE) ||
                        (next_s.mode == pms_pkg::PMS_RESTORE);
    next_s.fast_clk   = next_s.main_clk && (core_clk_req != '0);
    next_s.core_pwr   = (next_s.mode != pms_pkg::PMS_DEEP);
    next_s.core_rst_n = 1'b1;
    next_s.io_oe_n    = 1'b0;
    next_s.io_in_en   = 1'b1;

    // enable pin low: power-up values, except the hibernate copy, the tick sample and apb ready with error
    if (!regulator_enable_in) begin
      next_s            = '0;
      next_s.mode       = pms_pkg::PMS_OFF;
      next_s.cal_per    = pms_pkg::CAL_NOMINAL;
      next_s.lpo_q      = low_power_clock;
      next_s.hib_out    = hibernate_regulator_enable_in;
      next_s.pd_en      = 1'b1;
      next_s.io_oe_n    = 1'b1;
      next_s.io_in_en   = 1'b0;
      next_s.pready     = psel & ~penable;
      next_s.pslverr    = psel & ~penable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s          <= '0;
      s.cal_per  <= pms_pkg::CAL_NOMINAL;
      s.hib_out  <= 1'b1;
      s.pd_en    <= 1'b1;
      s.io_oe_n  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, straight from the state register
  assign prdata                         = s.prdata;
  assign pready                         = s.pready;
  assign pslverr                        = s.pslverr;
  assign hibernate_regulator_enable_out = s.hib_out;
  assign regulator_pulldown_en          = s.pd_en;
  assign regulators_on                  = s.reg_on;
  assign resource_enable                = s.res_en;
  assign main_clk_en                    = s.main_clk;
  assign fast_clk_sel                   = s.fast_clk;
  assign core_power_en                  = s.core_pwr;
  assign core_reset_n                   = s.core_rst_n;
  assign retention_save                 = s.save;
  assign retention_restore              = s.restore;
  assign io_output_enable_n             = s.io_oe_n;
  assign io_input_en                    = s.io_in_en;

endmodule : pms_resource_sequencer

// ==== sim/pms_seq_props.sv ====
// pms_seq_props: port-level checks on the power sequencer.
// assumes it is bound to pms_resource_sequencer and sees only its ports.
`timescale 1ns/100ps
module pms_seq_props #(
  parameter int NUM_RES = 8  // managed resources
) (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               regulator_enable_in,
  input wire logic               regulators_on,
  input wire logic               core_reset_n,
  input wire logic [NUM_RES-1:0] resource_enable,
  input wire logic               regulator_pulldown_en,
  input wire logic               hibernate_regulator_enable_in,
  input wire logic               hibernate_regulator_enable_out,
  input wire logic               retention_save,
  input wire logic               retention_restore,
  input wire logic               core_power_en,
  input wire logic               io_output_enable_n,
  input wire logic               io_input_en
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // apb setup phase; one-cycle save step
  sequence s_setup; psel && !penable; endsequence
  sequence s_save; retention_save ##1 !retention_save; endsequence
  a_pready_setup: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  a_pready_single: assert property (pready |=> !pready) else $error("ready held too long");
  a_slverr_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_regoff_reset: assert property (!regulator_enable_in |=> !regulators_on && !core_reset_n
    && regulator_pulldown_en && resource_enable == '0) else $error("not held off");
  a_regon_run: assert property (regulator_enable_in [*3] |-> regulators_on && core_reset_n)
    else $error("not running with enable high");
  a_hib_pass: assert property (regulator_enable_in |=>
    hibernate_regulator_enable_out == $past(hibernate_regulator_enable_in)) else $error("hibernate copy wrong");
  a_save_deep: assert property (s_save |-> ##[0:3] !core_power_en) else $error("no power off after save");
  a_io_tristate: assert property (!core_reset_n |-> io_output_enable_n && !io_input_en)
    else $error("io not isolated");
  a_restore_power: assert property (retention_restore |-> core_power_en && !retention_save)
    else $error("restore without core power");
endmodule : pms_seq_props
bind pms_resource_sequencer pms_seq_props #(.NUM_RES(NUM_RES)) u_props (.pclk, .presetn, .psel, .penable,
  .pready, .pslverr, .regulator_enable_in, .regulators_on, .core_reset_n, .resource_enable,
  .regulator_pulldown_en, .hibernate_regulator_enable_in, .hibernate_regulator_enable_out, .retention_save,
  .core_power_en, .io_output_enable_n, .io_input_en, .retention_restore);

// ==== sim/pms_host_model.sv ====
// pms_host_model: host logic on the regulator-enable pins.
// assumes the bench changes host_on and host_hib_keep just after a clock edge.
`timescale 1ns/100ps
module pms_host_model (
  input  wire logic host_on,                         // host wants the device powered
  input  wire logic host_hib_keep,                   // low asks hibernation to cut power
  input  wire logic hibernate_regulator_enable_out,  // board link source
  output logic      hibernate_regulator_enable_in,
  output logic      regulator_enable_in
);
  // hibernate request goes straight to its pin
  assign hibernate_regulator_enable_in = host_hib_keep;
  // board link feeds the enable pin; host cuts power by pulling it low
  assign regulator_enable_in = host_on && hibernate_regulator_enable_out;
endmodule : pms_host_model

// ==== sim/pms_resource_sequencer_bench.sv ====
// pms_resource_sequencer_bench: apb-driven checks of the power sequencer.
// assumes the host model drives both regulator-enable pins.
`timescale 1ns/100ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module pms_resource_sequencer_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, low_power_clock = 0, wake_irq = 0;
  logic host_on = 1, host_hib_keep = 1, err, pready, pslverr, regulator_enable_in, regulators_on;
  logic hibernate_regulator_enable_in, hibernate_regulator_enable_out, regulator_pulldown_en, main_clk_en;
  logic fast_clk_sel, core_power_en, core_reset_n, retention_save, retention_restore, io_output_enable_n;
  logic io_input_en;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] core_clk_req = '0;
  logic [7:0] resource_enable;
  int error_cnt = 0, tests_run = 0;
  pms_resource_sequencer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .low_power_clock, .core_clk_req, .wake_irq, .regulator_enable_in, .hibernate_regulator_enable_in,
    .hibernate_regulator_enable_out, .regulator_pulldown_en, .regulators_on, .resource_enable, .main_clk_en,
    .fast_clk_sel, .core_power_en, .core_reset_n, .retention_save, .retention_restore, .io_output_enable_n,
    .io_input_en);
  pms_host_model host (.host_on, .host_hib_keep, .hibernate_regulator_enable_out,
    .hibernate_regulator_enable_in, .regulator_enable_in);
  always #4 pclk = ~pclk;
  task final_report;
    if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  // one apb transfer: setup, access held until ready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk) penable <= 1;
    do @(posedge pclk) n++; while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    if (n >= 16) begin error_cnt++; final_report(); end
  endtask : apb
  task rchk(input string s, input logic [11:0] a, input logic [31:0] m, e);
    apb(0, a, '0);
    `CHK(s, e, rd & m)
  endtask : rchk
  // one low-power tick, 35 bus cycles apart, then a masked status read
  task tick_chk(input logic [31:0] m, e);
    @(posedge pclk) low_power_clock <= 1;
    @(posedge pclk) low_power_clock <= 0;
    repeat (30) @(posedge pclk);
    rchk("status", pms_pkg::OFS_STATUS, m, e);
  endtask : tick_chk
  task wake;
    @(posedge pclk) wake_irq <= 1;
    @(posedge pclk) wake_irq <= 0;
    repeat (4) @(posedge pclk);
  endtask : wake
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    rchk("calibration", pms_pkg::OFS_CAL, 32'hFFFFFFFF, {16'h0, pms_pkg::CAL_NOMINAL});
    apb(0, 12'h0FC, '0);
    `CHK("unmapped", 33'h100000000, {err, rd})
    apb(1, pms_pkg::OFS_RES_CFG, 32'h00000203);
    apb(1, pms_pkg::OFS_RES_CFG + 12'h004, 32'h00010000);
    apb(1, pms_pkg::OFS_CLK_MAP, 32'h00000002);
    apb(1, pms_pkg::OFS_MIN_SET, 32'h00000001);
    rchk("config", pms_pkg::OFS_RES_CFG, 32'hFFFFFFFF, 32'h00000203);
    core_clk_req <= 4'h1;
    tick_chk(32'h101, 32'h100);
    `CHK("enable", 1'b1, resource_enable[0])
    `CHK("fast clock", 1'b1, fast_clk_sel)
    repeat (2) tick_chk(32'h101, 32'h100);
    tick_chk(32'h101, 32'h001);
    tick_chk(32'h303, 32'h003);
    rchk("calibration", pms_pkg::OFS_CAL, 32'hFFFFFFFF, 32'h00000023);
    core_clk_req <= 4'h0;
    apb(1, pms_pkg::OFS_MIN_SET, 32'h00000000);
    tick_chk(32'h202, 32'h000);
    tick_chk(32'h101, 32'h101);
    tick_chk(32'h101, 32'h101);
    tick_chk(32'h303, 32'h000);
    `CHK("enable", 8'h00, resource_enable)
    apb(1, pms_pkg::OFS_CTRL, {29'h0, 1'b1, pms_pkg::REQ_DOZE});
    rchk("mode", pms_pkg::OFS_STATUS, 32'h70000, {13'h0, pms_pkg::PMS_DOZE, 16'h0});
    `CHK("main clock", 1'b0, main_clk_en)
    `CHK("pull-down", 1'b0, regulator_pulldown_en)
    wake();
    rchk("mode", pms_pkg::OFS_STATUS, 32'h70000, {13'h0, pms_pkg::PMS_ACTIVE, 16'h0});
    apb(1, pms_pkg::OFS_CTRL, {30'h0, pms_pkg::REQ_DEEP});
    repeat (4) @(posedge pclk);
    `CHK("core power", 1'b0, core_power_en)
    wake();
    `CHK("core power", 1'b1, core_power_en)
    rchk("mode", pms_pkg::OFS_STATUS, 32'h70000, {13'h0, pms_pkg::PMS_ACTIVE, 16'h0});
    apb(1, pms_pkg::OFS_CTRL, {30'h0, pms_pkg::REQ_DOZE});
    apb(1, pms_pkg::OFS_REQ_TIMER, 32'h00010001);
    tick_chk(32'h70101, {13'h0, pms_pkg::PMS_ACTIVE, 16'h0100});
    @(posedge pclk) host_on <= 0;
    repeat (3) @(posedge pclk);
    apb(0, pms_pkg::OFS_STATUS, '0);
    `CHK("off access", 2'b10, {err, regulators_on})
    @(posedge pclk) host_on <= 1;
    repeat (3) @(posedge pclk);
    rchk("clock map", pms_pkg::OFS_CLK_MAP, 32'hFFFFFFFF, 32'h0);
    @(posedge pclk) host_hib_keep <= 0;
    repeat (4) @(posedge pclk);
    `CHK("hibernate", 1'b0, regulators_on)
    @(posedge pclk) host_hib_keep <= 1;
    repeat (4) @(posedge pclk);
    `CHK("hibernate", 1'b1, regulators_on)
    final_report();
  end
endmodule : pms_resource_sequencer_bench
